// *** design/fms_readout_top.sv ***
// Behaviour
// - Results kept in RAM, readable any time
// - A result read restarts the current conversion
// - Fast reads may starve status updates
// - Analog codes unsigned 8-bit, 16 mV step
// - Fan counts divided oscillator over one period
// - Fan count saturates at 255
// - Divisor 1, 2, 4 or 8; reset 2
// - Fans 1, 2 programmable; fan 3 fixed 2
// - Count equals 1.35e6 over RPM times divisor
// - Fixed round robin: temp, inputs, fans
// - Loop runs with start high, clear low
`timescale 1ns/10ps
module fms_readout_top #(
  parameter int unsigned OSC_CYC_P  = fms_pkg::OSC_CYC,
  parameter int unsigned SLOT_CYC_P = fms_pkg::SLOT_CYC
) (
  input  wire logic                        sys_clk_in,
  input  wire logic                        srst_in,
  input  wire logic                        start_in,
  input  wire logic                        int_clear_in,
  input  wire logic                        div_we_in,
  input  wire logic [1:0]                  fan_divisor_select1_in,
  input  wire logic [1:0]                  fan_divisor_select2_in,
  input  wire logic [fms_pkg::NUM_FANS-1:0] tach_in,
  input  wire logic                        adc_done_in,
  input  wire logic [7:0]                  adc_result_in,
  input  wire logic                        rd_req_in,
  input  wire logic [4:0]                  rd_addr_in,
  input  wire logic                        wr_req_in,
  input  wire logic [4:0]                  wr_addr_in,
  input  wire logic [7:0]                  wr_data_in,
  output logic      [7:0]                  rd_data_out,
  output logic                             rd_valid_out,
  output logic                             adc_start_out,
  output logic                             adc_abort_out,
  output logic      [3:0]                  adc_chan_out,
  output logic                             loop_done_out,
  output logic                             running_out,
  output logic      [1:0]                  div1_out,
  output logic      [1:0]                  div2_out
);
  import fms_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (OSC_CYC_P < 2 || OSC_CYC_P >= (1 << OSC_W)) begin : g_chk_osc
    $error("oscillator divide out of range");
  end
  if (SLOT_CYC_P < 2 || SLOT_CYC_P >= (1 << SLOT_W)) begin : g_chk_slot
    $error("slot length out of range");
  end

  localparam logic [OSC_W-1:0]  OSC_LAST  = OSC_W'(OSC_CYC_P - 1);
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_CYC_P - 1);

  fms_top_t                 st_r;
  fms_top_t                 st_nxt;
  logic [NUM_FANS-1:0][1:0] fan_div;
  logic [NUM_FANS-1:0][7:0] fan_cnt;
  logic [NUM_FANS-1:0]      fan_done;

  function automatic logic is_fan(input logic [3:0] slot);
    is_fan = (slot >= FAN_FIRST);
  endfunction

  function automatic logic [1:0] fan_idx(input logic [3:0] slot);
    logic [3:0] d;
    d       = slot - FAN_FIRST;
    fan_idx = d[1:0];
  endfunction

  // ************************************************************
  // Fan tach counters
  // ************************************************************
  assign fan_div[0] = st_r.div1;
  assign fan_div[1] = st_r.div2;
  assign fan_div[2] = FAN3_DIV;

  for (genvar i = 0; i < NUM_FANS; i++) begin : g_fan
    fms_tach_counter u_tach (
      .sys_clk_in  (sys_clk_in),
      .srst_in     (srst_in),
      .tach_in     (tach_in[i]),
      .tick_in     (st_r.osc_tick),
      .div_code_in (fan_div[i]),
      .arm_in      (st_r.arm[i]),
      .count_out   (fan_cnt[i]),
      .done_out    (fan_done[i])
    );
  end

  // ************************************************************
  // Sequencer, value RAM and host access
  // ************************************************************
  always_comb begin
    logic       run;
    logic       tmr_end;
    logic       adv;
    logic [1:0] fi;
    run              = start_in & ~int_clear_in;
    tmr_end          = (st_r.slot_tmr == SLOT_LAST);
    adv              = 1'b0;
    fi               = fan_idx(st_r.slot);
    st_nxt           = st_r;
    st_nxt.osc_tick  = 1'b0;
    st_nxt.rd_valid  = 1'b0;
    st_nxt.adc_start = 1'b0;
    st_nxt.adc_abort = 1'b0;
    st_nxt.arm       = '0;
    st_nxt.loop_done = 1'b0;
    st_nxt.running   = run;
    st_nxt.slot_tmr  = st_r.slot_tmr + SLOT_W'(1);

    // Base 22.5 kHz tick shared by all fans
    if (st_r.osc_cnt == OSC_LAST) begin
      st_nxt.osc_cnt  = '0;
      st_nxt.osc_tick = 1'b1;
    end else begin
      st_nxt.osc_cnt = st_r.osc_cnt + OSC_W'(1);
    end

    if (div_we_in) begin
      st_nxt.div1 = fan_divisor_select1_in;
      st_nxt.div2 = fan_divisor_select2_in;
    end

    // Host writes (limits) land before sequencer results
    if (wr_req_in) begin
      st_nxt.vram[wr_addr_in] = wr_data_in;
    end

    if (rd_req_in) begin
      st_nxt.rd_data  = st_r.vram[rd_addr_in];
      st_nxt.rd_valid = 1'b1;
    end

    case (st_r.st)
      FMS_IDLE: begin
        st_nxt.slot     = '0;
        st_nxt.slot_tmr = '0;
        if (run) begin
          st_nxt.st = FMS_START;
        end
      end
      FMS_START: begin
        st_nxt.slot_tmr = '0;
        if (is_fan(st_r.slot)) begin
          st_nxt.arm[fi] = 1'b1;
        end else begin
          st_nxt.adc_start = 1'b1;
          st_nxt.adc_chan  = st_r.slot;
        end
        st_nxt.st = FMS_WAIT;
      end
      FMS_WAIT: begin
        if (is_fan(st_r.slot)) begin
          if (tmr_end) begin
            // Unfinished period means slowest speed
            st_nxt.vram[st_r.slot] = fan_done[fi] ? fan_cnt[fi]
                                                  : CNT_MAX;
            adv = 1'b1;
          end
        end else if (adc_done_in) begin
          // Code stored as is: 16 mV per step, 0 to 4.08 V
          st_nxt.vram[st_r.slot] = adc_result_in;
          st_nxt.st = tmr_end ? FMS_START : FMS_HOLD;
          adv = tmr_end;
        end else if (tmr_end) begin
          // Converter never answered; keep old value, move on
          st_nxt.adc_abort = 1'b1;
          adv = 1'b1;
        end
      end
      FMS_HOLD: begin
        if (tmr_end) begin
          adv = 1'b1;
        end
      end
      default: st_nxt.st = FMS_IDLE;
    endcase

    if (adv) begin
      st_nxt.st = FMS_START;
      if (st_r.slot == NUM_SLOTS - 4'h1) begin
        st_nxt.slot      = '0;
        st_nxt.loop_done = 1'b1;
      end else begin
        st_nxt.slot = st_r.slot + 4'h1;
      end
    end

    // Read halts the converter and redoes this slot; a steady
    // stream of reads can therefore keep the loop from finishing
    if (rd_req_in && run && st_r.st != FMS_IDLE) begin
      st_nxt.adc_abort = ~is_fan(st_r.slot);
      st_nxt.slot      = st_r.slot;
      st_nxt.loop_done = 1'b0;
      st_nxt.st        = FMS_START;
    end

    // No new conversion or arm may leave while stopping
    if (!run) begin
      st_nxt.st        = FMS_IDLE;
      st_nxt.adc_start = 1'b0;
      st_nxt.arm       = '0;
      if (st_r.st == FMS_WAIT && !is_fan(st_r.slot)) begin
        st_nxt.adc_abort = 1'b1;
      end
    end

    // Value RAM survives reset; contents undefined at power on
    if (srst_in) begin
      st_nxt          = '0;
      st_nxt.vram     = st_r.vram;
      st_nxt.div1     = DIV_RST;
      st_nxt.div2     = DIV_RST;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    st_r <= st_nxt;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Count = 1.35e6 / (RPM * div) falls out of the gated count
  assign rd_data_out   = st_r.rd_data;
  assign rd_valid_out  = st_r.rd_valid;
  assign adc_start_out = st_r.adc_start;
  assign adc_abort_out = st_r.adc_abort;
  assign adc_chan_out  = st_r.adc_chan;
  assign loop_done_out = st_r.loop_done;
  assign running_out   = st_r.running;
  assign div1_out      = st_r.div1;
  assign div2_out      = st_r.div2;

endmodule

// *** shared/fms_pkg.sv ***
package fms_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned OSC_HZ     = 22_500;
  localparam int unsigned OSC_CYC    = CLK_HZ / OSC_HZ;
  localparam int unsigned SLOT_MS    = 90;
  localparam int unsigned SLOT_CYC   = SLOT_MS * (CLK_HZ / 1000);
  localparam int unsigned OSC_W      = 13;
  localparam int unsigned SLOT_W     = 24;

  // ************************************************************
  // Loop and value RAM layout
  // ************************************************************
  localparam logic [3:0]  NUM_SLOTS  = 4'hB;
  localparam logic [3:0]  FAN_FIRST  = 4'h8;
  localparam int unsigned NUM_FANS   = 3;
  localparam int unsigned VRAM_DEPTH = 32;
  localparam logic [7:0]  VRAM_BASE  = 8'h20;
  localparam logic [7:0]  CNT_MAX    = 8'hFF;

  // ************************************************************
  // Fan divisor codes: 0..3 select 1, 2, 4, 8
  // ************************************************************
  localparam logic [1:0]  DIV_RST    = 2'h1;
  localparam logic [1:0]  FAN3_DIV   = 2'h1;

  typedef enum logic [1:0] {
    FMS_IDLE  = 2'b00,
    FMS_START = 2'b01,
    FMS_WAIT  = 2'b11,
    FMS_HOLD  = 2'b10
  } fms_state_t;

  typedef enum logic [1:0] {
    FMS_TP_IDLE  = 2'b00,
    FMS_TP_SEEK  = 2'b01,
    FMS_TP_COUNT = 2'b11
  } fms_tach_ph_t;

  typedef struct packed {
    logic         s1;
    logic         s2;
    logic         prev;
    fms_tach_ph_t ph;
    logic [2:0]   pre;
    logic [7:0]   cnt;
    logic         done;
  } fms_tach_t;

  typedef struct packed {
    fms_state_t          st;
    logic [3:0]          slot;
    logic [SLOT_W-1:0]   slot_tmr;
    logic [OSC_W-1:0]    osc_cnt;
    logic                osc_tick;
    logic [1:0]          div1;
    logic [1:0]          div2;
    logic [NUM_FANS-1:0] arm;
    logic [VRAM_DEPTH-1:0][7:0] vram;
    logic [7:0]          rd_data;
    logic                rd_valid;
    logic                adc_start;
    logic                adc_abort;
    logic [3:0]          adc_chan;
    logic                loop_done;
    logic                running;
  } fms_top_t;

endpackage

// *** design/fms_tach_counter.sv ***
`timescale 1ns/10ps
module fms_tach_counter (
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  input  wire logic       tach_in,
  input  wire logic       tick_in,
  input  wire logic [1:0] div_code_in,
  input  wire logic       arm_in,
  output logic      [7:0] count_out,
  output logic            done_out
);
  import fms_pkg::*;

  fms_tach_t st_r;
  fms_tach_t st_nxt;
  logic      rise;

  function automatic logic [2:0] div_last(input logic [1:0] code);
    case (code)
      2'h0:    div_last = 3'h0;
      2'h1:    div_last = 3'h1;
      2'h2:    div_last = 3'h3;
      default: div_last = 3'h7;
    endcase
  endfunction

  // Edge taken from second sync stage only
  assign rise = st_r.s2 & ~st_r.prev;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = tach_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.prev = st_r.s2;
    case (st_r.ph)
      FMS_TP_IDLE: begin
      end
      FMS_TP_SEEK: begin
        if (rise) begin
          st_nxt.ph = FMS_TP_COUNT;
        end
      end
      FMS_TP_COUNT: begin
        if (rise) begin
          st_nxt.ph   = FMS_TP_IDLE;
          st_nxt.done = 1'b1;
        end else if (tick_in) begin
          if (st_r.pre == div_last(div_code_in)) begin
            st_nxt.pre = 3'h0;
            if (st_r.cnt != CNT_MAX) begin
              st_nxt.cnt = st_r.cnt + 8'h01;
            end
          end else begin
            st_nxt.pre = st_r.pre + 3'h1;
          end
        end
      end
      default: st_nxt.ph = FMS_TP_IDLE;
    endcase
    if (arm_in) begin
      st_nxt.ph   = FMS_TP_SEEK;
      st_nxt.pre  = 3'h0;
      st_nxt.cnt  = 8'h00;
      st_nxt.done = 1'b0;
    end
    if (srst_in) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    st_r <= st_nxt;
  end

  assign count_out = st_r.cnt;
  assign done_out  = st_r.done;

endmodule

// *** sim/fms_readout_top_chk.sv ***
`timescale 1ns/10ps
module fms_chk (
  input wire logic       sys_clk_in,
  input wire logic       srst_in,
  input wire logic       start_in,
  input wire logic       int_clear_in,
  input wire logic       div_we_in,
  input wire logic [1:0] fan_divisor_select1_in,
  input wire logic [1:0] fan_divisor_select2_in,
  input wire logic       rd_req_in,
  input wire logic       rd_valid_out,
  input wire logic       adc_start_out,
  input wire logic       adc_abort_out,
  input wire logic [3:0] adc_chan_out,
  input wire logic       loop_done_out,
  input wire logic       running_out,
  input wire logic [1:0] div1_out,
  input wire logic [1:0] div2_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  rd_answer_a: assert property (
    rd_req_in |=> rd_valid_out) else $error("read not answered");
  rd_cause_a: assert property (
    rd_valid_out |-> $past(rd_req_in)) else $error("stray read answer");
  rd_restart_a: assert property (
    rd_req_in && running_out ##1 adc_abort_out
    |=> adc_start_out && $stable(adc_chan_out)) else $error("no restart");
  run_level_a: assert property (
    !$past(srst_in) |-> running_out == $past(start_in && !int_clear_in))
    else $error("run level wrong");
  first_chan_a: assert property (
    $rose(running_out) |=> adc_start_out && adc_chan_out == 4'h0)
    else $error("loop not from slot 0");
  chan_range_a: assert property (
    adc_start_out |-> adc_chan_out <= 4'h7) else $error("bad channel");
  div_load_a: assert property (
    div_we_in |=> div1_out == $past(fan_divisor_select1_in)
    && div2_out == $past(fan_divisor_select2_in)) else $error("div load");
  div_keep_a: assert property (
    !div_we_in |=> $stable(div1_out) && $stable(div2_out))
    else $error("divisor moved");
  stop_idle_a: assert property (
    int_clear_in [*3] |-> !adc_start_out) else $error("start while held");
  done_run_a: assert property (
    loop_done_out |-> $past(running_out)) else $error("idle loop end");
  cover property (rd_req_in && running_out);
  cover property (loop_done_out);
  cover property (div_we_in);
endmodule
bind fms_readout_top fms_chk u_chk (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .start_in(start_in),
  .int_clear_in(int_clear_in), .div_we_in(div_we_in),
  .fan_divisor_select1_in(fan_divisor_select1_in),
  .fan_divisor_select2_in(fan_divisor_select2_in),
  .rd_req_in(rd_req_in), .rd_valid_out(rd_valid_out),
  .adc_start_out(adc_start_out), .adc_abort_out(adc_abort_out),
  .adc_chan_out(adc_chan_out), .loop_done_out(loop_done_out),
  .running_out(running_out), .div1_out(div1_out), .div2_out(div2_out));

// *** sim/fms_partner.sv ***
`timescale 1ns/10ps
module fms_partner (
  input  wire logic             sys_clk_in,
  input  wire logic             adc_start_out,
  input  wire logic             adc_abort_out,
  input  wire logic [3:0]       adc_chan_out,
  input  wire logic [7:0][7:0]  codes,
  input  wire logic [2:0][15:0] per,
  output logic                  adc_done_in = 1'b0,
  output logic      [7:0]       adc_result_in = 8'h00,
  output logic      [2:0]       tach_in = 3'h0
);
  int c[3] = '{0, 0, 0};
  int lat  = -1;
  always @(posedge sys_clk_in) begin
    // Two pulses per turn; a zero period is a stopped fan
    for (int f = 0; f < 3; f++) begin
      c[f] <= (c[f] + 1 >= int'(per[f])) ? 0 : c[f] + 1;
      tach_in[f] <= per[f] != 0 && c[f] < int'(per[f]) / 2;
    end
    adc_done_in <= 1'b0;
    // Result lines carry junk outside the done pulse
    adc_result_in <= ~adc_result_in;
    if (adc_abort_out)
      lat <= -1;
    else if (adc_start_out)
      lat <= adc_chan_out[0] ? 3 : 60;
    else if (lat > 0)
      lat <= lat - 1;
    else if (lat == 0) begin
      adc_done_in <= 1'b1;
      adc_result_in <= codes[adc_chan_out[2:0]];
      lat <= -1;
    end
  end
endmodule

// *** sim/fms_readout_top_tb.sv ***
`timescale 1ns/10ps
module fms_readout_top_tb;
  import fms_pkg::*;
  logic             sys_clk_in = 0, srst_in = 1;
  logic             start_in = 0, int_clear_in = 0, div_we_in = 0;
  logic             rd_req_in = 0, wr_req_in = 0;
  logic [1:0]       fan_divisor_select1_in = 0, fan_divisor_select2_in = 0;
  logic [2:0]       tach_in;
  logic             adc_done_in, rd_valid_out, adc_start_out;
  logic [7:0]       adc_result_in, rd_data_out, wr_data_in = 0;
  logic [4:0]       rd_addr_in = 0, wr_addr_in = 0;
  logic             adc_abort_out, loop_done_out, running_out;
  logic [3:0]       adc_chan_out;
  logic [1:0]       div1_out, div2_out;
  logic [7:0][7:0]  codes = '0;
  logic [2:0][15:0] per = '0;
  logic [7:0]       rnd = 8'h17;
  logic [15:0]      cur, q[$];
  int               error_cnt = 0, num_checks = 0, cyc = 0;

  fms_readout_top #(.OSC_CYC_P(4), .SLOT_CYC_P(3000)) dut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .start_in(start_in),
    .int_clear_in(int_clear_in), .div_we_in(div_we_in),
    .fan_divisor_select1_in(fan_divisor_select1_in),
    .fan_divisor_select2_in(fan_divisor_select2_in), .tach_in(tach_in),
    .adc_done_in(adc_done_in), .adc_result_in(adc_result_in),
    .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in), .wr_req_in(wr_req_in),
    .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .adc_start_out(adc_start_out), .adc_abort_out(adc_abort_out),
    .adc_chan_out(adc_chan_out), .loop_done_out(loop_done_out),
    .running_out(running_out), .div1_out(div1_out), .div2_out(div2_out));
  fms_partner u_far (
    .sys_clk_in(sys_clk_in), .adc_start_out(adc_start_out),
    .adc_abort_out(adc_abort_out), .adc_chan_out(adc_chan_out),
    .codes(codes), .per(per), .adc_done_in(adc_done_in),
    .adc_result_in(adc_result_in), .tach_in(tach_in));

  always #5 sys_clk_in = ~sys_clk_in;

  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input logic [8:0] got, exp, tol);
    num_checks++;
    if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e, t);
    @(negedge sys_clk_in);
    rd_req_in = 1;
    rd_addr_in = a;
    q.push_back({t, e});
    @(negedge sys_clk_in);
    rd_req_in = 0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    wr_req_in = 1;
    wr_addr_in = a;
    wr_data_in = d;
    @(negedge sys_clk_in);
    wr_req_in = 0;
  endtask

  task automatic new_codes();
    for (int i = 0; i < 8; i++) begin
      rnd = nxt(rnd);
      codes[i] = rnd;
    end
  endtask

  task automatic wait_loop();
    repeat (40000) if (loop_done_out !== 1'b1) @(negedge sys_clk_in);
  endtask

  // Fan counts may differ by one tick of phase
  task automatic rd_all(input logic [7:0] f1, f2, f3);
    for (int i = 0; i < 8; i++) rd(i[4:0], codes[i], 0);
    rd(5'h08, f1, 1);
    rd(5'h09, f2, 1);
    rd(5'h0A, f3, 1);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(negedge sys_clk_in) begin
    if (rd_valid_out === 1'b1) begin
      cur = q.pop_front();
      chk(rd_data_out, cur[7:0], cur[15:8]);
    end
  end

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(negedge sys_clk_in);
    srst_in = 0;
    chk(div1_out, 1, 0);
    chk(div2_out, 1, 0);
    rnd = nxt(rnd);
    wr(5'h14, rnd);
    rd(5'h14, rnd, 0);
    fan_divisor_select1_in = 2'h0;
    fan_divisor_select2_in = 2'h3;
    div_we_in = 1;
    @(negedge sys_clk_in);
    div_we_in = 0;
    chk(div1_out, 0, 0);
    chk(div2_out, 3, 0);
    new_codes();
    // Fan 3 runs twice fan 1's period at twice the divisor
    per = {16'h04C8, 16'h0500, 16'h0264};
    start_in = 1;
    wait_loop();
    start_in = 0;
    repeat (4) @(negedge sys_clk_in);
    rd_all(8'h99, 8'h28, 8'h99);
    fan_divisor_select2_in = 2'h0;
    div_we_in = 1;
    @(negedge sys_clk_in);
    div_we_in = 0;
    chk(div2_out, 0, 0);
    start_in = 1;
    repeat (50) @(negedge sys_clk_in);
    rd(5'h00, codes[0], 0);
    new_codes();
    // Fan 1 just under full count (0xDB), fan 2 past full count, fan 3 stopped
    per = {16'h0000, 16'h0500, 16'h036C};
    wait_loop();
    int_clear_in = 1;
    repeat (4) @(negedge sys_clk_in);
    rd_all(8'hDB, 8'hFF, 8'hFF);
    repeat (4) @(negedge sys_clk_in);
    final_report();
  end
endmodule
